//--- design/dspdec_pkg.sv
// Package: opcode patterns, field layouts and decoded-instruction carrier types
package dspdec_pkg;

  localparam int unsigned DSPDEC_WORD_W = 16;

  // Upper-byte opcodes
  localparam logic [7:0] OP_PROG_TO_DATA_MOVE = 8'h a5;
  localparam logic [7:0] OP_DATA_MOVE_SRC     = 8'h a8;
  localparam logic [7:0] OP_DATA_MOVE_DST     = 8'h a9;
  localparam logic [7:0] OP_ACC_HIGH_LOAD     = 8'h 6a;
  localparam logic [7:0] OP_ACC_LOW_LOAD      = 8'h 69;
  localparam logic [7:0] OP_ACC_MULT_SHIFT    = 8'h 6b;
  localparam logic [7:0] OP_BIT_TEST_MULT     = 8'h 6f;
  localparam logic [7:0] OP_MULT_LOAD_ACC     = 8'h 70;
  localparam logic [7:0] OP_MULT_LOAD_PROD    = 8'h 71;
  localparam logic [7:0] OP_MULT_LOAD_MOVE    = 8'h 72;
  localparam logic [7:0] OP_MULT_LOAD_SUB     = 8'h 74;
  localparam logic [7:0] OP_PAGE_LOAD_MEM     = 8'h 0d;
  localparam logic [7:0] OP_STATUS_LOAD_ZERO  = 8'h 0e;
  localparam logic [7:0] OP_STATUS_LOAD_ONE   = 8'h 0f;
  localparam logic [7:0] OP_PORT_INPUT        = 8'h af;
  localparam logic [7:0] OP_ACC_SHORT_LOAD    = 8'h b9;
  // Upper-nibble and 12-bit prefixes, plus the 3-bit and 2-bit tags that follow a nibble prefix
  localparam logic [3:0]  OP_NIB_IMMED        = 4'h b;
  localparam logic [2:0]  OP_PAGE_IMMED_TAG   = 3'h 6;
  localparam logic [11:0] OP_AUX_COMPARE      = 12'h bf4;
  localparam logic [11:0] OP_ACC_LONG_LOAD    = 12'h bf8;
  localparam logic [11:0] OP_AUX_LONG_LOAD    = 12'h bf0;
  localparam logic [11:0] OP_STATUS_BIT       = 12'h be4;
  localparam logic [3:0]  OP_COND_BRANCH_NIB  = 4'h e;
  localparam logic [1:0]  OP_COND_BRANCH_SUB  = 2'h 0;
  localparam logic [1:0]  OP_COND_CALL_SUB    = 2'h 2;
  localparam logic [1:0]  OP_COND_RETURN_SUB  = 2'h 3;

  // Status bit selects (low nibble of the status bit operation)
  localparam logic [3:0] STB_DUAL_BLOCK_DATA  = 4'h 4;
  localparam logic [3:0] STB_INT_ENABLE       = 4'h 0;
  localparam logic [3:0] STB_CARRY_RESET      = 4'h e;
  localparam logic [3:0] STB_OVM_RESET        = 4'h 2;
  localparam logic [3:0] STB_SXM_RESET        = 4'h 6;
  localparam logic [3:0] STB_TC_RESET         = 4'h a;
  localparam logic [3:0] STB_XF_RESET         = 4'h c;

  // Condition source select encodings
  localparam logic [1:0] COND_SRC_PIN_LOW     = 2'h 0;
  localparam logic [1:0] COND_SRC_TC_SET      = 2'h 1;
  localparam logic [1:0] COND_SRC_TC_CLEAR    = 2'h 2;
  localparam logic [1:0] COND_SRC_NONE        = 2'h 3;

  // Flag condition field positions within the mask/state nibbles
  localparam int unsigned FLAG_Z_POS          = 3;
  localparam int unsigned FLAG_L_POS          = 2;
  localparam int unsigned FLAG_V_POS          = 1;
  localparam int unsigned FLAG_C_POS          = 0;

  localparam logic [1:0] WORDS_ONE            = 2'h 1;
  localparam logic [1:0] WORDS_TWO            = 2'h 2;
  localparam logic [2:0] CYC_ONE              = 3'h 1;
  localparam logic [2:0] CYC_TWO              = 3'h 2;
  localparam logic [2:0] CYC_THREE            = 3'h 3;
  localparam logic [2:0] CYC_FOUR             = 3'h 4;

  typedef enum logic [5:0] {
    DSPDEC_OP_NONE,
    DSPDEC_OP_PROG_TO_DATA_BLOCK_MOVE,
    DSPDEC_OP_DATA_MOVE_SRC_IMM,
    DSPDEC_OP_DATA_MOVE_DST_IMM,
    DSPDEC_OP_AUX_COMPARE,
    DSPDEC_OP_ACC_HIGH_LOAD,
    DSPDEC_OP_ACC_LOW_LOAD,
    DSPDEC_OP_ACC_LOAD_MULT_SHIFT,
    DSPDEC_OP_ACC_LOAD_SHIFTED,
    DSPDEC_OP_ACC_SHORT_LOAD,
    DSPDEC_OP_MULT_LOAD_ACCUMULATE,
    DSPDEC_OP_MULT_LOAD_PRODUCT,
    DSPDEC_OP_MULT_LOAD_MOVE,
    DSPDEC_OP_MULT_LOAD_SUBTRACT,
    DSPDEC_OP_AUX_LOAD_SHORT,
    DSPDEC_OP_AUX_LOAD_LONG,
    DSPDEC_OP_PAGE_LOAD_IMM,
    DSPDEC_OP_PAGE_LOAD_MEM,
    DSPDEC_OP_BIT_TEST_BY_OPERAND,
    DSPDEC_OP_PORT_INPUT,
    DSPDEC_OP_STATUS_LOAD_ZERO,
    DSPDEC_OP_STATUS_LOAD_ONE,
    DSPDEC_OP_STATUS_BIT,
    DSPDEC_OP_COND_BRANCH,
    DSPDEC_OP_COND_CALL,
    DSPDEC_OP_COND_RETURN
  } dspdec_op_type;

  typedef enum logic [3:0] {
    DSPDEC_SB_NONE,
    DSPDEC_SB_DUAL_BLOCK_DATA,
    DSPDEC_SB_INT_ENABLE,
    DSPDEC_SB_CARRY_RESET,
    DSPDEC_SB_OVM_RESET,
    DSPDEC_SB_SXM_RESET,
    DSPDEC_SB_TC_RESET,
    DSPDEC_SB_XF_RESET
  } dspdec_status_bit_type;

  // Fetch unit to decoder
  typedef struct packed {
    logic        valid;
    logic [15:0] word;
  } dspdec_fetch_type;

  // Processor flags used for condition evaluation
  typedef struct packed {
    logic zero;
    logic negative;
    logic overflow;
    logic carry;
    logic tc;
    logic io_pin_low;
  } dspdec_flags_type;

  // Decoded instruction to the datapath
  typedef struct packed {
    logic                  valid;
    dspdec_op_type         op;
    logic                  illegal;
    logic [1:0]            words;
    logic [2:0]            cycles;
    logic                  indirect;
    logic [6:0]            direct_addr;
    logic [7:0]            indirect_ctl;
    logic [7:0]            short_imm;
    logic [15:0]           long_word;
    logic [8:0]            page_value;
    logic [2:0]            aux_register_select;
    logic [3:0]            shift_amount_field;
    logic [1:0]            compare_select_field;
    logic [1:0]            condition_source_select;
    logic [3:0]            flag_mask;
    logic [3:0]            flag_state;
    logic                  condition_met;
    dspdec_status_bit_type status_bit;
    logic                  acc_clear;
  } dspdec_decoded_type;

endpackage : dspdec_pkg

//--- design/dspdec_field_split.sv
// Field extraction for the common operand forms of one instruction word
`timescale 1ns/10ps
`default_nettype none
module dspdec_field_split
  import dspdec_pkg::*;
(
  input  wire logic [15:0] word,
  output logic             indirect,
  output logic [6:0]       direct_addr,
  output logic [7:0]       indirect_ctl,
  output logic [7:0]       short_imm,
  output logic [2:0]       aux_sel,
  output logic [3:0]       shift_amt,
  output logic [1:0]       compare_sel,
  output logic [8:0]       page_value,
  output logic [1:0]       cond_src,
  output logic [3:0]       flag_mask,
  output logic [3:0]       flag_state
);
  always_comb
  begin
    indirect     = word[7];
    direct_addr  = word[6:0];
    indirect_ctl = word[7:0];
    short_imm    = word[7:0];
    aux_sel      = word[10:8];
    shift_amt    = word[3:0];
    compare_sel  = word[1:0];
    page_value   = word[8:0];
    cond_src     = word[9:8];
    flag_mask    = word[3:0];
    flag_state   = word[7:4];
  end
endmodule // dspdec_field_split
`default_nettype wire

//--- design/dspdec_cond_eval.sv
// Condition evaluation for conditional branch, call and return
`timescale 1ns/10ps
`default_nettype none
module dspdec_cond_eval
  import dspdec_pkg::*;
(
  input  wire logic [1:0]       cond_src,
  input  wire logic [3:0]       flag_mask,
  input  wire logic [3:0]       flag_state,
  input  wire dspdec_flags_type flags,
  output logic                  met
);
  logic [3:0] actual;
  logic [3:0] hits;
  logic       src_ok;
  logic       flag_ok;

  always_comb
  begin
    actual                = '0;
    actual[FLAG_Z_POS]    = flags.zero;
    actual[FLAG_L_POS]    = flags.negative;
    actual[FLAG_V_POS]    = flags.overflow;
    actual[FLAG_C_POS]    = flags.carry;
    // Any masked flag in its required state meets the test; an empty mask tests nothing
    hits    = flag_mask & ~(actual ^ flag_state);
    flag_ok = (flag_mask == 4'h0) || (hits != 4'h0);
    case (cond_src)
      COND_SRC_PIN_LOW:  src_ok = flags.io_pin_low;
      COND_SRC_TC_SET:   src_ok = flags.tc;
      COND_SRC_TC_CLEAR: src_ok = ~flags.tc;
      COND_SRC_NONE:     src_ok = 1'b1;
      default:           src_ok = 1'b1;
    endcase
    met = src_ok & flag_ok;
  end
endmodule // dspdec_cond_eval
`default_nettype wire

//--- design/dspdec_decoder.sv
// Instruction decoder for a subset of a 16-bit fixed-point DSP instruction set
// Summary of operation
// - Upper byte 1010 0101 is program-to-data block move, two words, three cycles.
// - 1011 1111 0100 01 plus field compares current aux register with register zero.
// - Upper byte 0110 1010 clears low accumulator, loads high half, one cycle.
// - Upper byte 0111 0010 loads multiplier operand, accumulates, moves data.
// - 1011 1111 1000 plus shift is two-word shifted accumulator load, two cycles.
// - 1011 0 plus register select loads aux register short immediate, two cycles.
// - 1011 110 plus nine-bit page loads page pointer immediate, two cycles.
// - Upper byte 0000 1101 loads page pointer from memory, two cycles.
// - Upper byte 0110 1111 tests bit chosen by multiplier operand into test flag.
// - Upper byte 1010 1111 is port input, port address in second word.
// - Upper bytes 0000 1110 and 0000 1111 load status zero and one.
// - Upper byte 1011 1001 loads accumulator short immediate; zero clears it.
// - Upper byte 0110 1011 loads accumulator shifted by multiplier operand.
// - Upper byte 0110 1001 loads low accumulator, no sign extension.
// - 1011 1111 0000 1 plus select loads aux register long immediate.
// - 0111 0000 and 0111 0001 load multiplier operand, accumulate or move product.
// - Upper byte 0111 0100 loads multiplier operand and subtracts product.
// - 1010 1000 and 1010 1001 are data block moves, two words, three cycles.
// - 1011 1110 0100 plus select is a status bit operation.
// - Condition source 00 pin low, 01 test set, 10 test clear, 11 none.
// - Low nibble masks flags, bits 4 to 7 give required flag state.
`timescale 1ns/10ps
`default_nettype none
module dspdec_decoder
  import dspdec_pkg::*;
(
  input  wire logic               mclk,
  input  wire logic               sys_rst,
  input  wire dspdec_fetch_type   fetch,
  input  wire dspdec_flags_type   flags,
  input  wire logic               exec_ready,
  output logic                    fetch_ready,
  output logic                    second_word_expected,
  output dspdec_decoded_type      decoded
);
  typedef enum logic [1:0] {
    DSPDEC_ST_OPCODE,
    DSPDEC_ST_OPERAND,
    DSPDEC_ST_HOLD
  } dspdec_phase_type;

  typedef struct packed {
    dspdec_phase_type   phase;
    dspdec_decoded_type pend;
    dspdec_decoded_type out;
  } dspdec_state_type;

  dspdec_state_type   state;
  dspdec_state_type   next_state;
  dspdec_decoded_type dec;
  logic               f_indirect;
  logic [6:0]         f_direct;
  logic [7:0]         f_ind_ctl;
  logic [7:0]         f_short;
  logic [2:0]         f_aux;
  logic [3:0]         f_shift;
  logic [1:0]         f_cmp;
  logic [8:0]         f_page;
  logic [1:0]         f_cond;
  logic [3:0]         f_mask;
  logic [3:0]         f_state;
  logic               cond_met;
  logic [7:0]         upper;
  logic [11:0]        upper12;

  dspdec_field_split u_fields (
    .word         (fetch.word),
    .indirect     (f_indirect),
    .direct_addr  (f_direct),
    .indirect_ctl (f_ind_ctl),
    .short_imm    (f_short),
    .aux_sel      (f_aux),
    .shift_amt    (f_shift),
    .compare_sel  (f_cmp),
    .page_value   (f_page),
    .cond_src     (f_cond),
    .flag_mask    (f_mask),
    .flag_state   (f_state)
  );

  dspdec_cond_eval u_cond (
    .cond_src   (f_cond),
    .flag_mask  (f_mask),
    .flag_state (f_state),
    .flags      (flags),
    .met        (cond_met)
  );

  assign upper   = fetch.word[15:8];
  assign upper12 = fetch.word[15:4];

  // Opcode word decode
  always_comb
  begin
    dec                         = '0;
    dec.valid                   = 1'b1;
    dec.words                   = WORDS_ONE;
    dec.cycles                  = CYC_ONE;
    dec.indirect                = f_indirect;
    dec.direct_addr             = f_direct;
    dec.indirect_ctl            = f_ind_ctl;
    dec.short_imm               = f_short;
    dec.aux_register_select     = f_aux;
    dec.shift_amount_field      = f_shift;
    dec.compare_select_field    = f_cmp;
    dec.page_value              = f_page;
    dec.condition_source_select = f_cond;
    dec.flag_mask               = f_mask;
    dec.flag_state              = f_state;
    dec.condition_met           = cond_met;
    dec.status_bit              = DSPDEC_SB_NONE;
    if (upper12 == OP_AUX_COMPARE && fetch.word[3:2] == 2'h 1)
    begin
      dec.op = DSPDEC_OP_AUX_COMPARE;
    end
    else if (upper12 == OP_ACC_LONG_LOAD)
    begin
      dec.op     = DSPDEC_OP_ACC_LOAD_SHIFTED;
      dec.words  = WORDS_TWO;
      dec.cycles = CYC_TWO;
    end
    else if (upper12 == OP_AUX_LONG_LOAD && fetch.word[3])
    begin
      dec.op                  = DSPDEC_OP_AUX_LOAD_LONG;
      dec.aux_register_select = fetch.word[2:0];
      dec.words               = WORDS_TWO;
      dec.cycles              = CYC_TWO;
    end
    else if (upper12 == OP_STATUS_BIT)
    begin
      dec.op = DSPDEC_OP_STATUS_BIT;
      case (fetch.word[3:0])
        STB_DUAL_BLOCK_DATA: dec.status_bit = DSPDEC_SB_DUAL_BLOCK_DATA;
        STB_INT_ENABLE:      dec.status_bit = DSPDEC_SB_INT_ENABLE;
        STB_CARRY_RESET:     dec.status_bit = DSPDEC_SB_CARRY_RESET;
        STB_OVM_RESET:       dec.status_bit = DSPDEC_SB_OVM_RESET;
        STB_SXM_RESET:       dec.status_bit = DSPDEC_SB_SXM_RESET;
        STB_TC_RESET:        dec.status_bit = DSPDEC_SB_TC_RESET;
        STB_XF_RESET:        dec.status_bit = DSPDEC_SB_XF_RESET;
        default:
        begin
          dec.op      = DSPDEC_OP_NONE;
          dec.illegal = 1'b1;
        end
      endcase
    end
    else if (fetch.word[15:12] == OP_NIB_IMMED && !fetch.word[11])
    begin
      dec.op     = DSPDEC_OP_AUX_LOAD_SHORT;
      dec.cycles = CYC_TWO;
    end
    else if (fetch.word[15:12] == OP_NIB_IMMED && fetch.word[11:9] == OP_PAGE_IMMED_TAG)
    begin
      dec.op     = DSPDEC_OP_PAGE_LOAD_IMM;
      dec.cycles = CYC_TWO;
    end
    else if (fetch.word[15:12] == OP_COND_BRANCH_NIB)
    begin
      dec.words  = WORDS_TWO;
      dec.cycles = cond_met ? CYC_FOUR : CYC_TWO;
      case (fetch.word[11:10])
        OP_COND_BRANCH_SUB: dec.op = DSPDEC_OP_COND_BRANCH;
        OP_COND_CALL_SUB:   dec.op = DSPDEC_OP_COND_CALL;
        OP_COND_RETURN_SUB:
        begin
          dec.op    = DSPDEC_OP_COND_RETURN;
          dec.words = WORDS_ONE;
        end
        default:
        begin
          dec.op      = DSPDEC_OP_NONE;
          dec.illegal = 1'b1;
          dec.words   = WORDS_ONE;
          dec.cycles  = CYC_ONE;
        end
      endcase
    end
    else
    begin
      case (upper)
        OP_PROG_TO_DATA_MOVE:
        begin
          dec.op     = DSPDEC_OP_PROG_TO_DATA_BLOCK_MOVE;
          dec.words  = WORDS_TWO;
          dec.cycles = CYC_THREE;
        end
        OP_DATA_MOVE_SRC, OP_DATA_MOVE_DST:
        begin
          dec.op     = (upper == OP_DATA_MOVE_SRC) ? DSPDEC_OP_DATA_MOVE_SRC_IMM
                                                   : DSPDEC_OP_DATA_MOVE_DST_IMM;
          dec.words  = WORDS_TWO;
          dec.cycles = CYC_THREE;
        end
        OP_ACC_HIGH_LOAD:    dec.op = DSPDEC_OP_ACC_HIGH_LOAD;
        OP_MULT_LOAD_MOVE:   dec.op = DSPDEC_OP_MULT_LOAD_MOVE;
        OP_BIT_TEST_MULT:    dec.op = DSPDEC_OP_BIT_TEST_BY_OPERAND;
        OP_ACC_MULT_SHIFT:   dec.op = DSPDEC_OP_ACC_LOAD_MULT_SHIFT;
        OP_ACC_LOW_LOAD:     dec.op = DSPDEC_OP_ACC_LOW_LOAD;
        OP_MULT_LOAD_ACC:    dec.op = DSPDEC_OP_MULT_LOAD_ACCUMULATE;
        OP_MULT_LOAD_PROD:   dec.op = DSPDEC_OP_MULT_LOAD_PRODUCT;
        OP_MULT_LOAD_SUB:    dec.op = DSPDEC_OP_MULT_LOAD_SUBTRACT;
        OP_PAGE_LOAD_MEM:
        begin
          dec.op     = DSPDEC_OP_PAGE_LOAD_MEM;
          dec.cycles = CYC_TWO;
        end
        OP_STATUS_LOAD_ZERO, OP_STATUS_LOAD_ONE:
        begin
          dec.op     = (upper == OP_STATUS_LOAD_ZERO) ? DSPDEC_OP_STATUS_LOAD_ZERO
                                                      : DSPDEC_OP_STATUS_LOAD_ONE;
          dec.cycles = CYC_TWO;
        end
        OP_PORT_INPUT:
        begin
          dec.op     = DSPDEC_OP_PORT_INPUT;
          dec.words  = WORDS_TWO;
          dec.cycles = CYC_TWO;
        end
        OP_ACC_SHORT_LOAD:
        begin
          dec.op        = DSPDEC_OP_ACC_SHORT_LOAD;
          dec.acc_clear = (f_short == 8'h 00);
        end
        default:
        begin
          dec.op      = DSPDEC_OP_NONE;
          dec.illegal = 1'b1;
        end
      endcase
    end
  end

  // Handshake: take a word while the output slot is free or being drained
  assign fetch_ready          = (state.phase != DSPDEC_ST_HOLD) || exec_ready;
  assign second_word_expected = (state.phase == DSPDEC_ST_OPERAND);
  assign decoded              = state.out;

  // Phase machine: opcode, operand, then hold until the datapath takes the result
  // A two-word opcode parks in pend so its operand never reaches the opcode decode
  always_comb
  begin
    next_state = state;
    if (state.out.valid && exec_ready)
    begin
      next_state.out.valid = 1'b0;
    end
    case (state.phase)
      DSPDEC_ST_OPCODE, DSPDEC_ST_HOLD:
      begin
        if (fetch.valid && fetch_ready)
        begin
          if (dec.words == WORDS_TWO)
          begin
            next_state.pend  = dec;
            next_state.phase = DSPDEC_ST_OPERAND;
          end
          else
          begin
            next_state.out   = dec;
            next_state.phase = DSPDEC_ST_HOLD;
          end
        end
        else if (!(state.out.valid && !exec_ready))
        begin
          next_state.phase = DSPDEC_ST_OPCODE;
        end
      end
      DSPDEC_ST_OPERAND:
      begin
        if (fetch.valid && fetch_ready)
        begin
          // Second word is an operand, never decoded as an opcode
          next_state.out           = state.pend;
          next_state.out.long_word = fetch.word;
          next_state.pend          = '0;
          next_state.phase         = DSPDEC_ST_HOLD;
        end
      end
      default:
      begin
        next_state.phase = DSPDEC_ST_OPCODE;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end
endmodule // dspdec_decoder
`default_nettype wire

//--- verification/dspdec_decoder_props.sv
// Checker for the decoder port behaviour
`timescale 1ns/10ps
`default_nettype none
module dspdec_decoder_props
  import dspdec_pkg::*;
(
  input wire logic               mclk,
  input wire logic               sys_rst,
  input wire dspdec_fetch_type   fetch,
  input wire dspdec_flags_type   flags,
  input wire logic               exec_ready,
  input wire logic               fetch_ready,
  input wire logic               second_word_expected,
  input wire dspdec_decoded_type decoded
);
  logic        take;
  logic        first;
  logic [15:0] prev_word;
  assign take  = fetch.valid && fetch_ready;
  assign first = take && !second_word_expected;
  always_ff @(posedge mclk)
  begin
    prev_word <= fetch.word;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_reset_clears_out: assert property (
    $fell(sys_rst) |-> !decoded.valid && !second_word_expected && fetch_ready)
    else $error("outputs not clear after reset");
  a_refuse_when_busy: assert property (
    decoded.valid && !exec_ready |-> !fetch_ready)
    else $error("word accepted while result waits");
  a_hold_until_taken: assert property (
    decoded.valid && !exec_ready |=> decoded.valid && $stable(decoded))
    else $error("result changed before taken");
  a_opcode_waits: assert property (
    first && fetch.word[15:8] inside {8'ha5, 8'ha8, 8'ha9, 8'haf}
    |=> second_word_expected && !decoded.valid)
    else $error("two-word opcode not waiting for operand");
  a_operand_lands: assert property (
    take && second_word_expected
    |=> decoded.valid && !second_word_expected && decoded.long_word == prev_word)
    else $error("operand word not placed in result");
  a_short_acc_load: assert property (
    first && fetch.word[15:8] == 8'hb9 |=> decoded.valid
    && decoded.op == DSPDEC_OP_ACC_SHORT_LOAD && decoded.short_imm == prev_word[7:0])
    else $error("short accumulator load wrong");
  a_move_three_cyc: assert property (
    decoded.valid && decoded.op inside {DSPDEC_OP_PROG_TO_DATA_BLOCK_MOVE,
    DSPDEC_OP_DATA_MOVE_SRC_IMM, DSPDEC_OP_DATA_MOVE_DST_IMM}
    |-> decoded.cycles == 3'h3 && decoded.words == 2'h2)
    else $error("block move counts wrong");
  a_long_two_cyc: assert property (
    decoded.valid && decoded.op inside {DSPDEC_OP_ACC_LOAD_SHIFTED,
    DSPDEC_OP_AUX_LOAD_LONG, DSPDEC_OP_PORT_INPUT}
    |-> decoded.cycles == 3'h2 && decoded.words == 2'h2)
    else $error("two-word load counts wrong");
  a_load_two_cyc: assert property (
    decoded.valid && decoded.op inside {DSPDEC_OP_STATUS_LOAD_ZERO, DSPDEC_OP_STATUS_LOAD_ONE,
    DSPDEC_OP_PAGE_LOAD_MEM, DSPDEC_OP_PAGE_LOAD_IMM, DSPDEC_OP_AUX_LOAD_SHORT}
    |-> decoded.cycles == 3'h2 && decoded.words == 2'h1)
    else $error("one-word load counts wrong");
  a_branch_cycles: assert property (
    decoded.valid && decoded.op == DSPDEC_OP_COND_BRANCH
    |-> decoded.cycles == (decoded.condition_met ? 3'h4 : 3'h2))
    else $error("branch cycles disagree with condition");
endmodule // dspdec_decoder_props
`default_nettype wire

//--- verification/dspdec_host_model.sv
// Fetch unit and datapath model facing the decoder
`timescale 1ns/10ps
`default_nettype none
module dspdec_host_model
  import dspdec_pkg::*;
(
  input  wire logic           mclk,
  input  wire logic           fetch_ready,
  output var dspdec_fetch_type fetch,
  output var logic            exec_ready
);
  initial
  begin
    fetch      = '0;
    exec_ready = 1'b1;
  end
  // Offers a word and holds it until an edge sees fetch_ready high
  task automatic send(input logic [15:0] w, output bit ok);
    ok = 1'b0;
    @(negedge mclk);
    fetch.valid = 1'b1;
    fetch.word  = w;
    for (int n = 0; n < 20 && !ok; n++)
    begin
      ok = (fetch_ready === 1'b1);
      @(negedge mclk);
    end
    fetch.valid = 1'b0;
    fetch.word  = ~w;
  endtask
  task automatic set_ready(input logic b);
    exec_ready = b;
  endtask
endmodule // dspdec_host_model
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the instruction decoder
`timescale 1ns/10ps
`default_nettype none
module testbench
  import dspdec_pkg::*;
;
  logic               mclk;
  logic               sys_rst;
  dspdec_fetch_type   fetch;
  dspdec_flags_type   flags;
  logic               exec_ready;
  logic               fetch_ready;
  logic               second_word_expected;
  dspdec_decoded_type decoded;
  int                 err_total;
  int                 samples_checked;

  dspdec_decoder u_dspdec_decoder (.mclk(mclk), .sys_rst(sys_rst), .fetch(fetch),
    .flags(flags), .exec_ready(exec_ready), .fetch_ready(fetch_ready),
    .second_word_expected(second_word_expected), .decoded(decoded));
  dspdec_host_model u_dspdec_host_model (.mclk(mclk), .fetch_ready(fetch_ready),
    .fetch(fetch), .exec_ready(exec_ready));

  task automatic wrap_up();
    if (err_total == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic put(input logic [15:0] w);
    bit ok;
    u_dspdec_host_model.send(w, ok);
    if (!ok)
    begin
      err_total++;
      wrap_up();
    end
  endtask
  task automatic run_one_word();
    logic [15:0] w [16] = '{16'h6a05, 16'h7205, 16'h0d05, 16'h6f05, 16'h0e05, 16'h0f05,
      16'hb97f, 16'h6b05, 16'h6905, 16'h7005, 16'h7105, 16'h7405, 16'hbf45, 16'hb5aa,
      16'hbd23, 16'hbe44};
    dspdec_op_type op [16] = '{DSPDEC_OP_ACC_HIGH_LOAD, DSPDEC_OP_MULT_LOAD_MOVE,
      DSPDEC_OP_PAGE_LOAD_MEM, DSPDEC_OP_BIT_TEST_BY_OPERAND,
      DSPDEC_OP_STATUS_LOAD_ZERO, DSPDEC_OP_STATUS_LOAD_ONE,
      DSPDEC_OP_ACC_SHORT_LOAD, DSPDEC_OP_ACC_LOAD_MULT_SHIFT,
      DSPDEC_OP_ACC_LOW_LOAD, DSPDEC_OP_MULT_LOAD_ACCUMULATE,
      DSPDEC_OP_MULT_LOAD_PRODUCT, DSPDEC_OP_MULT_LOAD_SUBTRACT,
      DSPDEC_OP_AUX_COMPARE, DSPDEC_OP_AUX_LOAD_SHORT,
      DSPDEC_OP_PAGE_LOAD_IMM, DSPDEC_OP_STATUS_BIT};
    logic [2:0] cy [16] = '{1, 1, 2, 1, 2, 2, 1, 1, 1, 1, 1, 1, 1, 2, 2, 1};
    for (int i = 0; i < 16; i++)
    begin
      put(w[i]);
      check(decoded.valid, 1'b1);
      check(decoded.op, op[i]);
      check(decoded.cycles, cy[i]);
      check(decoded.words, 2'h1);
    end
  endtask
  task automatic run_two_word();
    logic [15:0] w [6] = '{16'ha505, 16'ha805, 16'ha905, 16'haf05, 16'hbf87, 16'hbf0e};
    dspdec_op_type op [6] = '{DSPDEC_OP_PROG_TO_DATA_BLOCK_MOVE, DSPDEC_OP_DATA_MOVE_SRC_IMM,
      DSPDEC_OP_DATA_MOVE_DST_IMM, DSPDEC_OP_PORT_INPUT, DSPDEC_OP_ACC_LOAD_SHIFTED,
      DSPDEC_OP_AUX_LOAD_LONG};
    logic [2:0] cy [6] = '{3, 3, 3, 2, 2, 2};
    for (int i = 0; i < 6; i++)
    begin
      put(w[i]);
      check(second_word_expected, 1'b1);
      check(decoded.valid, 1'b0);
      put(16'h0060 + 16'(i)); // Plain data addresses only
      check(decoded.op, op[i]);
      check(decoded.words, 2'h2);
      check(decoded.cycles, cy[i]);
      check(decoded.long_word, 16'h0060 + 16'(i));
      check(decoded.shift_amount_field, w[i][3:0]);
    end
    check(decoded.aux_register_select, 3'h6);
  endtask
  task automatic run_fields();
    put(16'hb5aa);
    check({decoded.aux_register_select, decoded.short_imm}, 11'h5aa);
    put(16'hbd23);
    check(decoded.page_value, 9'h123);
    put(16'hbf47);
    check(decoded.compare_select_field, 2'h3);
    put(16'hb900);
    check({decoded.acc_clear, decoded.short_imm}, 9'h100);
    put(16'h6a85);
    check({decoded.indirect, decoded.direct_addr, decoded.indirect_ctl}, 16'h8585);
    put(16'hef00);
    check({decoded.op, decoded.words, decoded.cycles}, {DSPDEC_OP_COND_RETURN, 2'h1, 3'h4});
    put(16'hff00);
    check({decoded.illegal, decoded.op}, {1'b1, DSPDEC_OP_NONE});
  endtask
  task automatic run_status();
    logic [3:0] sel [7] = '{4'h4, 4'h0, 4'he, 4'h2, 4'h6, 4'ha, 4'hc};
    dspdec_status_bit_type sb [7] = '{DSPDEC_SB_DUAL_BLOCK_DATA, DSPDEC_SB_INT_ENABLE,
      DSPDEC_SB_CARRY_RESET, DSPDEC_SB_OVM_RESET, DSPDEC_SB_SXM_RESET, DSPDEC_SB_TC_RESET,
      DSPDEC_SB_XF_RESET};
    for (int i = 0; i < 7; i++)
    begin
      put({12'hbe4, sel[i]});
      check({decoded.illegal, decoded.status_bit}, {1'b0, sb[i]});
    end
    put(16'hbe41);
    check(decoded.illegal, 1'b1);
  endtask
  task automatic run_cond();
    logic [15:0] w [8] = '{16'he388, 16'he388, 16'he100, 16'he100, 16'he000, 16'he200,
      16'heb88, 16'he3cc};
    logic [5:0] f [8] = '{6'h20, 6'h00, 6'h02, 6'h00, 6'h01, 6'h02, 6'h20, 6'h10};
    logic m [8] = '{1, 0, 1, 0, 1, 0, 1, 1};
    for (int i = 0; i < 8; i++)
    begin
      flags = dspdec_flags_type'(f[i]);
      put(w[i]);
      put(16'h0100);
      check(decoded.op, w[i][11] ? DSPDEC_OP_COND_CALL : DSPDEC_OP_COND_BRANCH);
      check({decoded.condition_source_select, decoded.flag_state, decoded.flag_mask},
        w[i][9:0]);
      check(decoded.condition_met, m[i]);
      check(decoded.cycles, m[i] ? 3'h4 : 3'h2);
    end
  endtask
  task automatic run_stall();
    @(negedge mclk);
    u_dspdec_host_model.set_ready(1'b0);
    put(16'hb9c3);
    check(fetch_ready, 1'b0);
    repeat (3) @(negedge mclk);
    check({decoded.valid, decoded.short_imm}, 9'h1c3);
    u_dspdec_host_model.set_ready(1'b1);
    @(negedge mclk);
    check(decoded.valid, 1'b0);
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial
  begin
    sys_rst         = 1'b1;
    flags           = '0;
    err_total       = 0;
    samples_checked = 0;
    repeat (6) @(negedge mclk);
    sys_rst = 1'b0;
    check({decoded.valid, second_word_expected, fetch_ready}, 3'h1);
    run_one_word();
    run_two_word();
    run_fields();
    run_status();
    run_cond();
    run_stall();
    wrap_up();
  end
endmodule // testbench

bind dspdec_decoder dspdec_decoder_props u_dspdec_decoder_props (.mclk(mclk),
  .sys_rst(sys_rst), .fetch(fetch), .flags(flags), .exec_ready(exec_ready),
  .fetch_ready(fetch_ready), .second_word_expected(second_word_expected),
  .decoded(decoded));
`default_nettype wire
